// >>> hw/acwk_pkg.sv
/*
  Constants for the motion sensor interrupt and wake-up block: register
  addresses, field positions, reset values and pulse timing.
  Assumes a 20 MHz clock and an 8-bit register port driven by the
  serial interface logic elsewhere in the sensor.
*/
package acwk_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SRC1     = 8'h16;
  localparam logic [7:0] ADDR_SRC2     = 8'h17;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_RELEASE  = 8'h1A;
  localparam logic [7:0] ADDR_MAIN     = 8'h1B;
  localparam logic [7:0] ADDR_RATE     = 8'h1D;
  localparam logic [7:0] ADDR_PIN_CTL  = 8'h1E;
  localparam logic [7:0] ADDR_WAKE_MSK = 8'h1F;
  localparam logic [7:0] ADDR_WAKE_DUR = 8'h29;
  localparam logic [7:0] ADDR_INACT    = 8'h2B;
  localparam logic [7:0] ADDR_LEVEL_HI = 8'h6A;
  localparam logic [7:0] ADDR_LEVEL_LO = 8'h6B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_EN_BIT    = 5;
  localparam int unsigned PIN_POL_BIT   = 4;
  localparam int unsigned PIN_PULSE_BIT = 3;
  localparam int unsigned UNLATCHED_WAKE_MODE_BIT    = 7;
  localparam int unsigned OPERATE_BIT   = 7;
  localparam int unsigned DRDY_EN_BIT   = 5;
  localparam int unsigned WAKE_EN_BIT   = 1;
  localparam int unsigned STAT_INT_BIT  = 4;
  localparam int unsigned SRC_DRDY_BIT  = 4;
  localparam int unsigned SRC_WAKE_BIT  = 1;
  localparam int unsigned RATE_W        = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MAIN     = 8'h00;
  localparam logic [7:0] RST_PIN_CTL  = 8'h00;
  localparam logic [7:0] RST_WAKE_MSK = 8'h3F;
  localparam logic [7:0] RST_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PULSE_MIN_NS  = 30000;
  localparam int unsigned PULSE_CYC     =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    WK_IDLE   = 3'b001,
    WK_COUNT  = 3'b010,
    WK_ACTIVE = 3'b100
  } acwk_state_e;

endpackage

// >>> hw/acwk_pin_drive.sv
/*
  Physical interrupt pin driver: enable, polarity and latched or pulsed
  output. Assumes the request and trigger inputs are synchronous.
*/
module acwk_pin_drive #(
  parameter int unsigned PULSE_CYC = 600,
  parameter int unsigned CNT_W     = 10
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Configuration
  input  wire logic pin_en_i,
  input  wire logic pol_high_i,
  input  wire logic pulse_sel_i,
  // Request
  input  wire logic irq_i,
  input  wire logic trig_i,
  // Pin
  output logic      pin_o
);

  // Refused at elaboration: the counter could not hold the pulse length
  if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin : g_bad_pulse
    $error("PULSE_CYC does not fit the pulse counter");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             pin_d;
  logic             active;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end else if (pulse_sel_i && trig_i) begin
      cnt_d = CNT_W'(PULSE_CYC);
    end
    active = pulse_sel_i ? (cnt_d != '0) : irq_i;
    pin_d  = (pin_en_i && active) ? pol_high_i : !pol_high_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      pin_o <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      pin_o <= pin_d;
    end
  end

endmodule // acwk_pin_drive

// >>> hw/acwk_irq_wake.sv
/*
  Interrupt and wake-up logic of a three-axis motion sensor: control
  registers, data-ready and wake-up sources, motion detection and the
  interrupt pin. Assumes an 8-bit register port from the serial
  interface, acceleration samples in 1/256 g, and a motion sample strobe
  at the rate chosen by the motion rate register.
*/
module acwk_irq_wake
  import acwk_pkg::*;
#(
  parameter int unsigned ACC_W = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [7:0]       reg_rdata_o,
  // Sample path
  input  wire logic             sample_valid_i,
  input  wire logic             accel_read_i,
  input  wire logic             motion_sample_i,
  input  wire logic [ACC_W-1:0] accel_x_i,
  input  wire logic [ACC_W-1:0] accel_y_i,
  input  wire logic [ACC_W-1:0] accel_z_i,
  // Interrupt pin
  output logic                  int_pin_o
);

  // Refused at elaboration: narrower samples cannot hold the threshold
  if (ACC_W < 13) begin : g_bad_width
    $error("ACC_W must hold a signed 12-bit threshold");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]      pin_ctl_q, pin_ctl_d, wake_msk_q, wake_msk_d;
  logic [7:0]      main_q, main_d, dur_q, dur_d, inact_q, inact_d;
  logic [7:0]      lvl_hi_q, lvl_hi_d, lvl_lo_q, lvl_lo_d;
  logic [7:0]      cnt_q, cnt_d, na_cnt_q, na_cnt_d, rdata_d;
  logic [RATE_W-1:0] rate_q, rate_d;
  logic            drdy_pend_q, drdy_pend_d, wake_pend_q, wake_pend_d;
  logic [5:0]      dir_q, dir_d;
  acwk_state_e     state_q, state_d;

  logic            rel_rd, drdy_set, wake_set, expire, hit, irq, wake_on;
  logic [5:0]      exceed, qual;
  logic [11:0]     level;
  logic signed [ACC_W-1:0] lvl_s;
  logic [ACC_W-1:0] acc [3];

  assign acc[0] = accel_x_i;
  assign acc[1] = accel_y_i;
  assign acc[2] = accel_z_i;
  assign level  = {lvl_hi_q, lvl_lo_q[7:4]};
  assign lvl_s  = ACC_W'($signed({1'b0, level}));

  // ----------------------------------------------------------------
  // Per-axis threshold compare
  // ----------------------------------------------------------------
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign exceed[4-2*a] = $signed(acc[a]) > lvl_s;
    assign exceed[5-2*a] = $signed(acc[a]) < -lvl_s;
  end

  assign qual    = exceed & wake_msk_q[5:0];
  assign hit     = motion_sample_i && (qual != 6'h00);
  assign wake_on = main_q[WAKE_EN_BIT] && main_q[OPERATE_BIT];
  assign rel_rd  = reg_rd_i && (reg_addr_i == ADDR_RELEASE);
  assign irq     = drdy_pend_q || wake_pend_q;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    pin_ctl_d  = pin_ctl_q;
    wake_msk_d = wake_msk_q;
    main_d     = main_q;
    rate_d     = rate_q;
    dur_d      = dur_q;
    inact_d    = inact_q;
    lvl_hi_d   = lvl_hi_q;
    lvl_lo_d   = lvl_lo_q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_PIN_CTL:  pin_ctl_d  = reg_wdata_i;
        ADDR_WAKE_MSK: wake_msk_d = reg_wdata_i;
        ADDR_MAIN:     main_d     = reg_wdata_i;
        ADDR_RATE:     rate_d     = reg_wdata_i[RATE_W-1:0];
        ADDR_WAKE_DUR: dur_d      = reg_wdata_i;
        ADDR_INACT:    inact_d    = reg_wdata_i;
        ADDR_LEVEL_HI: lvl_hi_d   = reg_wdata_i;
        ADDR_LEVEL_LO: lvl_lo_d   = {reg_wdata_i[7:4], 4'h0};
        default:       ;
      endcase
    end
    case (reg_addr_i)
      ADDR_SRC1:     rdata_d = 8'(drdy_pend_q) << SRC_DRDY_BIT |
                               8'(wake_pend_q) << SRC_WAKE_BIT;
      ADDR_SRC2:     rdata_d = {2'b00, dir_q};
      ADDR_STATUS:   rdata_d = 8'(irq) << STAT_INT_BIT;
      ADDR_RELEASE:  rdata_d = 8'(irq) << STAT_INT_BIT;
      ADDR_MAIN:     rdata_d = main_q;
      ADDR_RATE:     rdata_d = 8'(rate_q);
      ADDR_PIN_CTL:  rdata_d = pin_ctl_q;
      ADDR_WAKE_MSK: rdata_d = wake_msk_q;
      ADDR_WAKE_DUR: rdata_d = dur_q;
      ADDR_INACT:    rdata_d = inact_q;
      ADDR_LEVEL_HI: rdata_d = lvl_hi_q;
      ADDR_LEVEL_LO: rdata_d = lvl_lo_q;
      default:       rdata_d = 8'h00;
    endcase
    if (!reg_rd_i) begin
      rdata_d = reg_rdata_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_ctl_q   <= RST_PIN_CTL;
      wake_msk_q  <= RST_WAKE_MSK;
      main_q      <= RST_MAIN;
      rate_q      <= '0;
      dur_q       <= RST_ZERO;
      inact_q     <= RST_ZERO;
      lvl_hi_q    <= RST_ZERO;
      lvl_lo_q    <= RST_ZERO;
      reg_rdata_o <= RST_ZERO;
    end else begin
      pin_ctl_q   <= pin_ctl_d;
      wake_msk_q  <= wake_msk_d;
      main_q      <= main_d;
      rate_q      <= rate_d;
      dur_q       <= dur_d;
      inact_q     <= inact_d;
      lvl_hi_q    <= lvl_hi_d;
      lvl_lo_q    <= lvl_lo_d;
      reg_rdata_o <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up detector and interrupt sources
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    na_cnt_d = na_cnt_q;
    wake_set = 1'b0;
    expire   = 1'b0;
    case (state_q)
      WK_IDLE: begin
        if (hit) begin
          if (9'(cnt_q) + 9'h001 >= 9'(dur_q)) begin
            state_d  = WK_ACTIVE;
            wake_set = 1'b1;
          end else begin
            state_d = WK_COUNT;
            cnt_d   = 8'h01;
          end
        end
      end
      WK_COUNT: begin
        if (motion_sample_i) begin
          if (!hit) begin
            state_d = WK_IDLE;
            cnt_d   = 8'h00;
          end else if (9'(cnt_q) + 9'h001 >= 9'(dur_q)) begin
            state_d  = WK_ACTIVE;
            wake_set = 1'b1;
            cnt_d    = 8'h00;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
      WK_ACTIVE: begin
        // No new wake can start until the inactivity count runs out or wake_on drops
        if (hit) begin
          na_cnt_d = 8'h00;
        end else if (motion_sample_i) begin
          if (9'(na_cnt_q) + 9'h001 >= 9'(inact_q)) begin
            state_d  = WK_IDLE;
            na_cnt_d = 8'h00;
            expire   = 1'b1;
          end else begin
            na_cnt_d = na_cnt_q + 8'h01;
          end
        end
      end
      default: begin
        state_d = WK_IDLE;
        cnt_d   = 8'h00;
      end
    endcase
    if (!wake_on) begin
      state_d  = WK_IDLE;
      cnt_d    = 8'h00;
      na_cnt_d = 8'h00;
      wake_set = 1'b0;
      expire   = 1'b0;
    end
    drdy_set = sample_valid_i && main_q[DRDY_EN_BIT] &&
               main_q[OPERATE_BIT];
    // Set wins over any clear arriving in the same cycle
    drdy_pend_d = drdy_set ? 1'b1 :
                  (rel_rd || accel_read_i) ? 1'b0 : drdy_pend_q;
    wake_pend_d = wake_set ? 1'b1 :
                  (rel_rd || (expire && wake_msk_q[UNLATCHED_WAKE_MODE_BIT])) ? 1'b0 :
                  wake_pend_q;
    dir_d = wake_set ? qual : (rel_rd ? 6'h00 : dir_q);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q     <= WK_IDLE;
      cnt_q       <= 8'h00;
      na_cnt_q    <= 8'h00;
      drdy_pend_q <= 1'b0;
      wake_pend_q <= 1'b0;
      dir_q       <= 6'h00;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      na_cnt_q    <= na_cnt_d;
      drdy_pend_q <= drdy_pend_d;
      wake_pend_q <= wake_pend_d;
      dir_q       <= dir_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin
  // ----------------------------------------------------------------
  acwk_pin_drive #(
    .PULSE_CYC (PULSE_CYC),
    .CNT_W     (10)
  ) u_pin (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .pin_en_i    (pin_ctl_q[PIN_EN_BIT]),
    .pol_high_i  (pin_ctl_q[PIN_POL_BIT]),
    .pulse_sel_i (pin_ctl_q[PIN_PULSE_BIT]),
    .irq_i       (irq),
    .trig_i      (drdy_set || wake_set),
    .pin_o       (int_pin_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic en, pol, pls;
  assign en  = pin_ctl_q[PIN_EN_BIT];
  assign pol = pin_ctl_q[PIN_POL_BIT];
  assign pls = pin_ctl_q[PIN_PULSE_BIT];

  sequence s_release;
    rel_rd && !drdy_set && !wake_set;
  endsequence

  a_pin_disabled_idle: assert property (
    !en && !reg_wr_i |=> int_pin_o == !pol)
    else $error("disabled pin not idle");
  a_pin_polarity: assert property (
    en && !pls && !irq && !reg_wr_i |=> int_pin_o == !pol)
    else $error("enabled pin not at idle level");
  a_latch_hold: assert property (
    en && !pls && irq && !reg_wr_i |=> int_pin_o == pol)
    else $error("latched pin not asserted");
  a_pulse_start: assert property (
    en && pls && (drdy_set || wake_set) && !reg_wr_i &&
    int_pin_o == !pol && $past(int_pin_o) == !pol
    |=> int_pin_o == pol ##1 int_pin_o == pol)
    else $error("pulse did not start");
  a_release_clears: assert property (
    s_release |=> !drdy_pend_q && !wake_pend_q && dir_q == 6'h00)
    else $error("release read did not clear sources");
  a_accel_read_clr: assert property (
    accel_read_i && !drdy_set |=> !drdy_pend_q)
    else $error("data read did not clear data-ready");
  a_drdy_enable: assert property (
    sample_valid_i && main_q == 8'hA0 |=> drdy_pend_q)
    else $error("data-ready not raised");
  a_wake_gated: assert property (
    !main_q[WAKE_EN_BIT] |-> !wake_set ##1 state_q == WK_IDLE)
    else $error("wake-up active while disabled");
  a_wake_masked: assert property (
    wake_set |-> motion_sample_i && (exceed & wake_msk_q[5:0]) != 6'h00
    ##1 dir_q != 6'h00)
    else $error("wake-up from masked or quiet axis");
  a_wake_once: assert property (
    state_q == WK_ACTIVE |-> !wake_set)
    else $error("second wake-up while active");
  a_wake_count: assert property (
    wake_set && dur_q > 8'h01 |-> state_q == WK_COUNT &&
    9'(cnt_q) + 9'h001 >= 9'(dur_q))
    else $error("wake-up before timer count");
  a_count_restart: assert property (
    motion_sample_i && !hit && state_q == WK_COUNT && wake_on
    |=> cnt_q == 8'h00 && state_q == WK_IDLE)
    else $error("wake counter not restarted");
  a_unlatch_clear: assert property (
    expire && wake_msk_q[UNLATCHED_WAKE_MODE_BIT] && !rel_rd |=> !wake_pend_q)
    else $error("unlatched wake not cleared");
  a_reset_enables: assert property (
    @(posedge clk_i) disable iff (1'b0)
    reset_i |=> !main_q[DRDY_EN_BIT] && !main_q[WAKE_EN_BIT])
    else $error("interrupt enables set after reset");

endmodule // acwk_irq_wake

// >>> test/acwk_host_gpio.sv
/*
  Host GPIO model: watches the interrupt pin, counts activations and
  measures the length of each active stretch in clock cycles.
  Assumes the host tells it the programmed pin sense.
*/
module acwk_host_gpio (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Pin and programmed sense
  input  wire logic        pin_i,
  input  wire logic        pol_high_i,
  // Observations
  output logic [15:0]      edges_o,
  output logic [15:0]      pulse_len_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        active;
  logic        was_q;
  logic [15:0] run_q;

  // The handler only samples the pin, never touches the bus
  assign active = (pin_i == pol_high_i);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      was_q       <= 1'b0;
      run_q       <= '0;
      edges_o     <= '0;
      pulse_len_o <= '0;
    end else begin
      was_q <= active;
      if (active && !was_q) begin
        edges_o <= edges_o + 16'h0001;
        run_q   <= 16'h0001;
      end else if (active) begin
        run_q <= run_q + 16'h0001;
      end else if (was_q) begin
        pulse_len_o <= run_q;
      end
    end
  end
endmodule // acwk_host_gpio

// >>> test/tb_acwk_irq_wake.sv
/*
  Self-checking bench for the interrupt and wake-up block.
  Assumes the host GPIO model in acwk_host_gpio and a 20 MHz clock.
*/
module tb_acwk_irq_wake;
  timeunit 1ns;
  timeprecision 100ps;
  import acwk_pkg::*;

  logic        clk_i, reset_i, reg_wr_i, reg_rd_i, int_pin_o, pol_high;
  logic        sample_valid_i, accel_read_i, motion_sample_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
  logic [15:0] accel_x_i, accel_y_i, accel_z_i, edges, plen, e0;
  int          err_total, samples_checked;

  acwk_irq_wake #(.ACC_W(16)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
    .accel_read_i(accel_read_i), .motion_sample_i(motion_sample_i),
    .accel_x_i(accel_x_i), .accel_y_i(accel_y_i), .accel_z_i(accel_z_i),
    .int_pin_o(int_pin_o));

  acwk_host_gpio host (
    .clk_i(clk_i), .reset_i(reset_i), .pin_i(int_pin_o),
    .pol_high_i(pol_high), .edges_o(edges), .pulse_len_o(plen));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wt(input int n);
    repeat (n) tick();
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Strobes are dropped and one edge passes, so calls may follow at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    tick();
    rd_v = reg_rdata_o;
  endtask

  task automatic strobe(input bit new_data);
    if (new_data) sample_valid_i = 1'b1;
    else accel_read_i = 1'b1;
    tick();
    sample_valid_i = 1'b0;
    accel_read_i   = 1'b0;
    tick();
  endtask

  task automatic ms(input logic [15:0] x, y, z, input int n);
    accel_x_i = x;
    accel_y_i = y;
    accel_z_i = z;
    repeat (n) begin
      motion_sample_i = 1'b1;
      tick();
      motion_sample_i = 1'b0;
      tick();
    end
  endtask

  task automatic cfg(input logic [7:0] pc, msk, mn);
    wr(ADDR_MAIN, 8'h00);
    rd(ADDR_RELEASE);
    wr(ADDR_PIN_CTL, pc);
    wr(ADDR_WAKE_MSK, msk);
    wr(ADDR_MAIN, mn);
    pol_high = pc[4];
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk(int_pin_o, 1'b1);
    rd(ADDR_MAIN);
    chk(rd_v & 8'h22, 8'h00);
    rd(ADDR_PIN_CTL);
    chk(rd_v, 8'h00);
    rd(ADDR_WAKE_MSK);
    chk(rd_v, 8'h3F);
    wr(ADDR_SRC1, 8'hFF);
    rd(ADDR_SRC1);
    chk(rd_v, 8'h00);
    rd(8'h00);
    chk(rd_v, 8'h00);
    wr(ADDR_RATE, 8'hFF);
    rd(ADDR_RATE);
    chk(rd_v, 8'h07);
    wr(ADDR_LEVEL_LO, 8'hFF);
    rd(ADDR_LEVEL_LO);
    chk(rd_v, 8'hF0);
  endtask

  task automatic t_drdy;
    cfg(8'h30, 8'h3F, 8'h80);
    strobe(1);
    wt(2);
    chk(int_pin_o, 1'b0);
    wr(ADDR_MAIN, 8'hA0);
    strobe(1);
    wt(2);
    chk(int_pin_o, 1'b1);
    wt(20);
    chk(int_pin_o, 1'b1);
    rd(ADDR_STATUS);
    chk(rd_v & 8'h10, 8'h10);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h12, 8'h10);
    rd(ADDR_RELEASE);
    wt(2);
    chk(int_pin_o, 1'b0);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h12, 8'h00);
    strobe(1);
    strobe(0);
    wt(2);
    rd(ADDR_STATUS);
    chk(rd_v & 8'h10, 8'h00);
    chk(int_pin_o, 1'b0);
  endtask

  // Pin control value against idle and active pin level
  task automatic t_pins;
    logic [7:0] pc [4];
    logic [3:0] idl;
    logic [3:0] act;
    pc  = '{8'h20, 8'h10, 8'h00, 8'h30};
    idl = 4'b0101;
    act = 4'b1100;
    for (int i = 0; i < 4; i++) begin
      cfg(pc[i], 8'h3F, 8'hA0);
      wt(2);
      chk(int_pin_o, idl[i]);
      strobe(1);
      wt(2);
      chk(int_pin_o, act[i]);
    end
  endtask

  task automatic t_pulse;
    cfg(8'h38, 8'h3F, 8'hA0);
    wt(2);
    e0 = edges;
    strobe(1);
    wt(2);
    chk(int_pin_o, 1'b1);
    strobe(1);
    wt(PULSE_CYC + 20);
    chk(plen, 16'(PULSE_CYC));
    chk(edges - e0, 16'h0001);
    chk(int_pin_o, 1'b0);
  endtask

  task automatic t_wake;
    cfg(8'h30, 8'h3F, 8'h00);
    wr(ADDR_WAKE_DUR, 8'h03);
    wr(ADDR_INACT, 8'h02);
    wr(ADDR_LEVEL_HI, 8'h08);
    wr(ADDR_LEVEL_LO, 8'h00);
    wr(ADDR_MAIN, 8'h80);
    ms(16'h00C8, 16'h0000, 16'h0000, 3);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h00);
    wr(ADDR_MAIN, 8'h82);
    ms(16'h0081, 16'h0000, 16'h0000, 2);
    ms(16'h0080, 16'h0000, 16'h0000, 1);
    ms(16'h0081, 16'h0000, 16'h0000, 2);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h00);
    ms(16'h0081, 16'h0000, 16'h0000, 1);
    wt(2);
    chk(int_pin_o, 1'b1);
    rd(ADDR_SRC2);
    chk(rd_v, 8'h10);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h02);
    // Still active: motion must not raise a second wake
    ms(16'h0081, 16'h0000, 16'h0000, 2);
    rd(ADDR_RELEASE);
    ms(16'h0081, 16'h0000, 16'h0000, 1);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h00);
    ms(16'h0000, 16'h0000, 16'h0000, 2);
    ms(16'h0000, 16'hFF38, 16'h0000, 3);
    rd(ADDR_SRC2);
    chk(rd_v, 8'h08);
  endtask

  task automatic t_mask;
    cfg(8'h30, 8'hBF, 8'h82);
    ms(16'h0000, 16'h0000, 16'h00C8, 3);
    rd(ADDR_SRC2);
    chk(rd_v, 8'h01);
    ms(16'h0000, 16'h0000, 16'h0000, 1);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h02);
    ms(16'h0000, 16'h0000, 16'h0000, 1);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h00);
    wt(2);
    chk(int_pin_o, 1'b0);
    cfg(8'h30, 8'h2F, 8'h82);
    ms(16'h00C8, 16'h0000, 16'h0000, 3);
    rd(ADDR_SRC1);
    chk(rd_v & 8'h02, 8'h00);
    ms(16'hFF38, 16'h0000, 16'h0000, 3);
    rd(ADDR_SRC2);
    chk(rd_v, 8'h20);
  endtask

  // Reset in mid-run must drop enables, sources and the pin
  task automatic t_rerun;
    cfg(8'h20, 8'h3F, 8'hA2);
    strobe(1);
    chk(int_pin_o, 1'b0);
    reset_i = 1'b1;
    wt(3);
    reset_i = 1'b0;
    chk(int_pin_o, 1'b1);
    rd(ADDR_MAIN);
    chk(rd_v & 8'h22, 8'h00);
    rd(ADDR_SRC1);
    chk(rd_v, 8'h00);
  endtask

  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Whole run is under a thousand cycles; this is over twenty times that
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  initial begin
    err_total       = 0;
    samples_checked = 0;
    reset_i         = 1'b1;
    reg_wr_i        = 1'b0;
    reg_rd_i        = 1'b0;
    reg_addr_i      = 8'h00;
    reg_wdata_i     = 8'h00;
    sample_valid_i  = 1'b0;
    accel_read_i    = 1'b0;
    motion_sample_i = 1'b0;
    accel_x_i       = 16'h0000;
    accel_y_i       = 16'h0000;
    accel_z_i       = 16'h0000;
    pol_high        = 1'b0;
    rd_v            = 8'h00;
    repeat (3) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_drdy();
    t_pins();
    t_pulse();
    t_wake();
    t_mask();
    t_rerun();
    stop_test();
  end
endmodule // tb_acwk_irq_wake
